// >>> verilog/dpp_directional_overpower_fn.sv
// directional over-power protection with ahb-lite register slave
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
// Summary of operation
// R1: power from fundamental voltage and current phasors
// R2: boundary line through set point, perpendicular
// R3: operate when projection lies strictly beyond line
// R4: hysteresis lowers threshold while operating
// R5: start when power farther than line point
// R6: general block suppresses general start
// R7: vt supervision block suppresses general start
// R8: start without start-only begins delay timer
// R9: trip at expiry; never with start-only
// R10: two block inputs, start and trip outputs
// R11: delay 200..60000 ms default 200; off default
// R12: power 1.0..200.0 %, angle -179..180
// R13: start and trip reported as on/off events
// R14: start drop clears timer and trip
// R15: disabled holds outputs low, timer cleared
module dpp_directional_overpower_fn
    import dpp_pkg::*;
#(
    parameter int DW         = 16,         // phasor component width
    parameter int NOM_PER_01 = 32'h0000_4000, // power units per 0.1 %
    parameter int CYC_MS     = CYC_PER_MS  // clocks per millisecond
)
(
    // clock and reset
    input  wire logic                        CLOCK,
    input  wire logic                        SYS_RST,
    // ahb-lite slave
    input  wire logic                        HSEL,
    input  wire logic [31:0]                 HADDR,
    input  wire logic [1:0]                  HTRANS,
    input  wire logic                        HWRITE,
    input  wire logic [2:0]                  HSIZE,
    input  wire logic [31:0]                 HWDATA,
    input  wire logic                        HREADY,
    output logic [31:0]                      HRDATA,
    output logic                             HREADYOUT,
    output logic                             HRESP,
    // fundamental phasors per phase, real and imaginary
    input  wire logic                        MEAS_VALID,
    input  wire logic signed [2:0][DW-1:0]   U_RE,
    input  wire logic signed [2:0][DW-1:0]   U_IM,
    input  wire logic signed [2:0][DW-1:0]   I_RE,
    input  wire logic signed [2:0][DW-1:0]   I_IM,
    // blocking inputs from user logic
    input  wire logic                        BLOCK_INPUT_STATUS,
    input  wire logic                        VT_BLOCK_INPUT_STATUS,
    // status outputs
    output logic                             GENERAL_START_OUT,
    output logic                             GENERAL_TRIP_OUT,
    output logic                             IRQ
);

    localparam int PW = 2 * DW + 2; // three-phase power width
    localparam int CW = PW + 2;     // cordic growth headroom

    // ==========================================================
    // state machine of the measurement path
    typedef enum logic [3:0] {
        M_IDLE = 4'b0001, // waiting for phasors
        M_SUM  = 4'b0010, // adding phase products
        M_ROT  = 4'b0100, // projection running
        M_DEC  = 4'b1000  // comparing with threshold
    } dpp_meas_t;

    dpp_meas_t                 meas_r;      // path state
    logic signed [2*DW:0]      pp_r [3];    // per-phase active
    logic signed [2*DW:0]      qq_r [3];    // per-phase reactive
    logic signed [PW-1:0]      p_r;         // three-phase p
    logic signed [PW-1:0]      q_r;         // three-phase q
    logic                      cor_go_r;    // projection request
    logic                      cor_done;    // projection ready
    logic signed [CW-1:0]      cor_proj;    // scaled projection
    logic [47:0]               thr_r;       // scaled threshold
    logic [47:0]               thr_eff;     // threshold in use
    logic                      dir_op_r;    // directional decision

    // settings
    logic                      en_r;        // function on
    logic                      sonly_r;     // start signal only
    logic [10:0]               spwr_r;      // start power, 0.1 %
    logic signed [8:0]         angle_r;     // direction angle
    logic [15:0]               delay_r;     // trip delay, ms

    // blocking synchronisers
    logic [1:0]                blk_sync_r;  // general block
    logic [1:0]                vt_sync_r;   // vt supervision block

    // decision and timer
    logic                      start_nxt;   // general start wanted
    logic [16:0]               pre_r;       // millisecond prescaler
    logic [15:0]               ms_r;        // elapsed milliseconds

    // bus and interrupt
    logic                      ph_wr_r;     // write data phase due
    logic [7:0]                ph_addr_r;   // latched offset
    logic                      acc;         // valid address phase
    logic [EV_W-1:0]           ev_stat_r;   // sticky events
    logic [EV_W-1:0]           ev_mask_r;   // event mask
    logic [EV_W-1:0]           ev_set;      // events this cycle
    logic                      stat_rd;     // status being read
    logic [31:0]               rd_mux;      // read data selection

    // ==========================================================
    // per-phase complex power u * conj(i)
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++)
        begin : g_phase
            // signed parts widened before the products
            logic signed [2*DW:0] ur, ui, ir, ii; // sign-extended parts
            assign ur = (2*DW+1)'($signed(U_RE[ph]));
            assign ui = (2*DW+1)'($signed(U_IM[ph]));
            assign ir = (2*DW+1)'($signed(I_RE[ph]));
            assign ii = (2*DW+1)'($signed(I_IM[ph]));
            always_ff @(posedge CLOCK or posedge SYS_RST)
            begin
                if (SYS_RST)
                begin
                    pp_r[ph] <= '0;
                    qq_r[ph] <= '0;
                end
                else if (MEAS_VALID && meas_r == M_IDLE)
                begin
                    pp_r[ph] <= ur * ir + ui * ii; // R1
                    qq_r[ph] <= ui * ir - ur * ii; // R1
                end
            end
        end
    endgenerate

    // ==========================================================
    // measurement sequence: sum, project, decide
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            meas_r   <= M_IDLE;
            p_r      <= '0;
            q_r      <= '0;
            cor_go_r <= 1'b0;
        end
        else
        begin
            cor_go_r <= 1'b0;
            unique case (meas_r)
                M_IDLE:
                    if (MEAS_VALID)
                        meas_r <= M_SUM;
                M_SUM:
                begin
                    // three-phase sums
                    p_r <= PW'(pp_r[0]) + PW'(pp_r[1]) + PW'(pp_r[2]); // R1
                    q_r <= PW'(qq_r[0]) + PW'(qq_r[1]) + PW'(qq_r[2]); // R1
                    cor_go_r <= 1'b1;
                    meas_r   <= M_ROT;
                end
                M_ROT:
                    if (cor_done)
                        meas_r <= M_DEC;
                M_DEC:
                    meas_r <= M_IDLE;
            endcase
        end
    end

    // projection of (p, q) on the set direction
    dpp_cordic_proj #(
        .W         (CW)
    ) u_proj (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .start     (cor_go_r),
        .x_in      (CW'(p_r)),
        .y_in      (CW'(q_r)),
        .angle_deg (angle_r),
        .done      (cor_done),
        .proj      (cor_proj)
    );

    // ==========================================================
    // set point magnitude, scaled by the rotation gain
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            thr_r <= '0;
        else
            thr_r <= (48'(spwr_r) * 48'(NOM_PER_01)
                      * 48'(CORDIC_GAIN)) >> 10; // R2
    end

    // lowered threshold while already operating
    assign thr_eff = dir_op_r
        ? thr_r - ((thr_r * 48'(HYST_NUM)) >> HYST_SHIFT) // R4
        : thr_r;

    // ==========================================================
    // directional decision, once per measurement
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            dir_op_r <= 1'b0;
        else if (!en_r)
            dir_op_r <= 1'b0;
        else if (meas_r == M_DEC)
            // strictly beyond the line means farther than its point
            dir_op_r <= (cor_proj > 0)
                     && (48'(cor_proj) > thr_eff); // R3 R5
    end

    // ==========================================================
    // two-flop synchronisers for the blocking inputs
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            blk_sync_r <= '0;
            vt_sync_r  <= '0;
        end
        else
        begin
            blk_sync_r <= {blk_sync_r[0], BLOCK_INPUT_STATUS}; // R10
            vt_sync_r  <= {vt_sync_r[0], VT_BLOCK_INPUT_STATUS}; // R10
        end
    end

    // start gated by enable and both blocks
    assign start_nxt = en_r && dir_op_r
                    && !blk_sync_r[1] // R6
                    && !vt_sync_r[1]; // R7

    // ==========================================================
    // general start output
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            GENERAL_START_OUT <= 1'b0;
        else
            GENERAL_START_OUT <= start_nxt; // R15
    end

    // ==========================================================
    // definite delay timer in whole milliseconds
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pre_r <= '0;
            ms_r  <= '0;
        end
        else if (!GENERAL_START_OUT || sonly_r || !en_r)
        begin
            // idle or dropped start: cleared
            pre_r <= '0; // R14 R15
            ms_r  <= '0; // R14 R15
        end
        else if (ms_r < delay_r)
        begin
            // timing while start stands
            if (pre_r == 17'(CYC_MS - 1))
            begin
                pre_r <= '0;
                ms_r  <= ms_r + 16'h0001; // R8
            end
            else
                pre_r <= pre_r + 17'h00001; // R8
        end
    end

    // ==========================================================
    // general trip output
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            GENERAL_TRIP_OUT <= 1'b0;
        else
            GENERAL_TRIP_OUT <= start_nxt && GENERAL_START_OUT
                             && !sonly_r && en_r
                             && (ms_r >= delay_r); // R9 R14 R15
    end

    // ==========================================================
    // on/off events of start and trip
    assign ev_set[EV_ST_ON_BIT]  = start_nxt && !GENERAL_START_OUT; // R13
    assign ev_set[EV_ST_OFF_BIT] = !start_nxt && GENERAL_START_OUT; // R13
    assign ev_set[EV_TR_ON_BIT]  = !GENERAL_TRIP_OUT && start_nxt
        && GENERAL_START_OUT && !sonly_r && en_r
        && (ms_r >= delay_r); // R13
    assign ev_set[EV_TR_OFF_BIT] = GENERAL_TRIP_OUT && !(start_nxt
        && GENERAL_START_OUT && !sonly_r && en_r
        && (ms_r >= delay_r)); // R13

    // ==========================================================
    // ahb-lite address phase
    assign acc = HSEL && HREADY && HTRANS[1];
    assign stat_rd = acc && !HWRITE && (HADDR[7:0] == OFS_IRQ_STAT)
                  && (HADDR[31:8] == 24'h000000);

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ph_wr_r   <= 1'b0;
            ph_addr_r <= '0;
            HREADYOUT <= 1'b0;
            HRESP     <= 1'b0;
        end
        else
        begin
            ph_wr_r   <= acc && HWRITE && (HADDR[31:8] == 24'h000000);
            HREADYOUT <= 1'b1; // zero wait states
            HRESP     <= 1'b0; // always okay
            if (acc)
                ph_addr_r <= HADDR[7:0];
        end
    end

    // read data selection; unmapped reads zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (HADDR[31:8] == 24'h000000)
        begin
            unique case (HADDR[7:0])
                OFS_CTRL:      rd_mux = {30'h0, sonly_r, en_r};
                OFS_START_PWR: rd_mux = {21'h0, spwr_r};
                OFS_DIR_ANGLE: rd_mux = 32'(angle_r);
                OFS_DELAY:     rd_mux = {16'h0, delay_r};
                OFS_STATE:     rd_mux = {27'h0, vt_sync_r[1],
                                   blk_sync_r[1], dir_op_r,
                                   GENERAL_TRIP_OUT, GENERAL_START_OUT};
                OFS_IRQ_STAT:  rd_mux = {28'h0, ev_stat_r};
                OFS_IRQ_MASK:  rd_mux = {28'h0, ev_mask_r};
                OFS_P:         rd_mux = p_r[PW-1 -: 32];
                OFS_Q:         rd_mux = q_r[PW-1 -: 32];
                default:       rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // read data registered at the end of the address phase
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            HRDATA <= '0;
        else if (acc && !HWRITE)
            HRDATA <= rd_mux;
    end

    // ==========================================================
    // settings written in the data phase, clamped to range
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            {sonly_r, en_r} <= CTRL_RST; // R11
            spwr_r    <= START_PWR_RST; // R12
            angle_r   <= ANGLE_RST; // R12
            delay_r   <= DELAY_RST; // R11
            ev_mask_r <= '0;
        end
        else if (ph_wr_r)
        begin
            unique case (ph_addr_r)
                OFS_CTRL:
                    {sonly_r, en_r} <= HWDATA[1:0];
                OFS_START_PWR:
                    if (HWDATA[31:0] < 32'(START_PWR_MIN))
                        spwr_r <= START_PWR_MIN; // R12
                    else if (HWDATA[31:0] > 32'(START_PWR_MAX))
                        spwr_r <= START_PWR_MAX; // R12
                    else
                        spwr_r <= HWDATA[10:0];
                OFS_DIR_ANGLE:
                    if ($signed(HWDATA) < 32'(ANGLE_MIN))
                        angle_r <= ANGLE_MIN; // R12
                    else if ($signed(HWDATA) > 32'(ANGLE_MAX))
                        angle_r <= ANGLE_MAX; // R12
                    else
                        angle_r <= HWDATA[8:0];
                OFS_DELAY:
                    if (HWDATA[31:0] < 32'(DELAY_MIN))
                        delay_r <= DELAY_MIN; // R11
                    else if (HWDATA[31:0] > 32'(DELAY_MAX))
                        delay_r <= DELAY_MAX; // R11
                    else
                        delay_r <= HWDATA[15:0];
                OFS_IRQ_MASK:
                    ev_mask_r <= HWDATA[EV_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // ==========================================================
    // sticky events: read clears, a new event wins
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            ev_stat_r <= '0;
        else if (stat_rd)
            ev_stat_r <= ev_set;
        else
            ev_stat_r <= ev_stat_r | ev_set;
    end

    // level interrupt from unmasked events
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            IRQ <= 1'b0;
        else
            IRQ <= |((stat_rd ? ev_set : (ev_stat_r | ev_set))
                     & ev_mask_r);
    end

endmodule

// >>> pkg/dpp_pkg.sv
// shared constants of the directional over-power protection block
package dpp_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00; // enable, start only
    localparam logic [7:0] OFS_START_PWR = 8'h04; // start power, 0.1 %
    localparam logic [7:0] OFS_DIR_ANGLE = 8'h08; // direction, degrees
    localparam logic [7:0] OFS_DELAY     = 8'h0c; // trip delay, ms
    localparam logic [7:0] OFS_STATE     = 8'h10; // live state, read only
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h14; // sticky events
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h18; // event mask
    localparam logic [7:0] OFS_P         = 8'h1c; // active power
    localparam logic [7:0] OFS_Q         = 8'h20; // reactive power

    // ==========================================================
    // field positions
    localparam int CTRL_EN_BIT     = 0; // function on
    localparam int CTRL_SONLY_BIT  = 1; // start signal only
    localparam int EV_ST_ON_BIT    = 0; // general start raised
    localparam int EV_ST_OFF_BIT   = 1; // general start dropped
    localparam int EV_TR_ON_BIT    = 2; // general trip raised
    localparam int EV_TR_OFF_BIT   = 3; // general trip dropped
    localparam int EV_W            = 4; // number of events

    // ==========================================================
    // setting ranges and reset values
    localparam logic [10:0] START_PWR_MIN = 11'h00a; // 1.0 %
    localparam logic [10:0] START_PWR_MAX = 11'h7d0; // 200.0 %
    localparam logic [10:0] START_PWR_RST = 11'h064; // 10.0 %
    localparam logic signed [8:0] ANGLE_MIN = -9'sd179; // degrees
    localparam logic signed [8:0] ANGLE_MAX = 9'sd180;  // degrees
    localparam logic signed [8:0] ANGLE_RST = 9'sd0;    // degrees
    localparam logic [15:0] DELAY_MIN = 16'h00c8; // 200 ms
    localparam logic [15:0] DELAY_MAX = 16'hea60; // 60000 ms
    localparam logic [15:0] DELAY_RST = 16'h00c8; // 200 ms
    localparam logic [1:0]  CTRL_RST  = 2'h0;     // off, trip enabled

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;      // 100 MHz
    localparam int MS_NS         = 1000000; // one millisecond
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

    // ==========================================================
    // arithmetic constants
    localparam int CORDIC_ITER = 12;          // rotation steps
    localparam int ANG_FRAC    = 8;           // degree fraction bits
    localparam logic [10:0] CORDIC_GAIN = 11'h696; // 1.6465 * 1024
    localparam int HYST_SHIFT  = 8;           // hysteresis divider
    localparam logic [4:0] HYST_NUM = 5'h0d;  // 13/256 = 5 %

endpackage

// >>> verilog/dpp_cordic_proj.sv
// iterative cordic: projects a power point onto a direction
`timescale 1ns/1ns
module dpp_cordic_proj
    import dpp_pkg::*;
#(
    parameter int W = 36 // datapath width
)
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // request
    input  wire logic                start,
    input  wire logic signed [W-1:0] x_in,
    input  wire logic signed [W-1:0] y_in,
    input  wire logic signed [8:0]   angle_deg,
    // answer
    output logic                     done,
    output logic signed [W-1:0]      proj
);

    // ==========================================================
    // arctangent table, degrees with eight fraction bits
    function automatic logic signed [17:0] atan_deg(input int i);
        logic signed [17:0] v;
        v = 18'sd0;
        case (i)
            0: v = 18'sd11520;
            1: v = 18'sd6801;
            2: v = 18'sd3593;
            3: v = 18'sd1824;
            4: v = 18'sd916;
            5: v = 18'sd458;
            6: v = 18'sd229;
            7: v = 18'sd115;
            8: v = 18'sd57;
            9: v = 18'sd29;
            10: v = 18'sd14;
            default: v = 18'sd7;
        endcase
        return v;
    endfunction

    localparam logic signed [17:0] QUARTER = 18'sd23040; // 90 deg

    logic signed [W-1:0] x_r;    // rotating x
    logic signed [W-1:0] y_r;    // rotating y
    logic signed [17:0]  z_r;    // remaining angle
    logic [3:0]          step_r; // iteration index
    logic                busy_r; // rotation running
    logic signed [17:0]  z0;     // negated direction angle

    // rotate by minus the direction: x ends as p*cos + q*sin
    assign z0 = -(18'(angle_deg) <<< ANG_FRAC);

    // ==========================================================
    // pre-rotation into range, then one step per clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            x_r    <= '0;
            y_r    <= '0;
            z_r    <= '0;
            step_r <= '0;
            busy_r <= 1'b0;
        end
        else if (start)
        begin
            // bring the angle inside plus/minus ninety degrees
            if (z0 > QUARTER)
            begin
                x_r <= -y_in;
                y_r <= x_in;
                z_r <= z0 - QUARTER;
            end
            else if (z0 < -QUARTER)
            begin
                x_r <= y_in;
                y_r <= -x_in;
                z_r <= z0 + QUARTER;
            end
            else
            begin
                x_r <= x_in;
                y_r <= y_in;
                z_r <= z0;
            end
            step_r <= '0;
            busy_r <= 1'b1;
        end
        else if (busy_r)
        begin
            // micro-rotation toward zero residual angle
            if (z_r >= 0)
            begin
                x_r <= x_r - (y_r >>> step_r);
                y_r <= y_r + (x_r >>> step_r);
                z_r <= z_r - atan_deg(int'(step_r));
            end
            else
            begin
                x_r <= x_r + (y_r >>> step_r);
                y_r <= y_r - (x_r >>> step_r);
                z_r <= z_r + atan_deg(int'(step_r));
            end
            step_r <= step_r + 4'h1;
            if (step_r == 4'(CORDIC_ITER - 1))
                busy_r <= 1'b0;
        end
    end

    // ==========================================================
    // result pulse one cycle after the last step
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done <= 1'b0;
            proj <= '0;
        end
        else
        begin
            done <= busy_r && (step_r == 4'(CORDIC_ITER - 1));
            proj <= x_r;
        end
    end

endmodule

// >>> testbench/dpp_chk_properties.sv
// port assertions of the over-power block
`timescale 1ns/1ns
module dpp_chk
    import dpp_pkg::*;
#(parameter int CYC_MS = 10)
(
    input wire logic CLOCK, SYS_RST, HREADYOUT,
    input wire logic BLOCK_INPUT_STATUS, VT_BLOCK_INPUT_STATUS,
    input wire logic GENERAL_START_OUT, GENERAL_TRIP_OUT
);
    int st_cnt; // cycles the start has stood
    always_ff @(posedge CLOCK or posedge SYS_RST)
        if (SYS_RST) st_cnt <= 0;
        else st_cnt <= GENERAL_START_OUT ? st_cnt + 1 : 0;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    sequence s_blk; BLOCK_INPUT_STATUS [*6]; endsequence
    sequence s_vt; VT_BLOCK_INPUT_STATUS [*6]; endsequence
    a_ready_out: assert property (!$past(SYS_RST) |-> HREADYOUT)
        else $error("ready low");
    a_block_start: assert property (s_blk |-> !GENERAL_START_OUT)
        else $error("start while blocked");
    a_block_trip: assert property (s_blk |-> !GENERAL_TRIP_OUT)
        else $error("trip while blocked");
    a_vt_start: assert property (s_vt |-> !GENERAL_START_OUT)
        else $error("start while vt blocked");
    a_trip_start:
        assert property (GENERAL_TRIP_OUT |-> $past(GENERAL_START_OUT))
        else $error("trip without start");
    a_fresh_start:
        assert property ($rose(GENERAL_START_OUT) |-> !GENERAL_TRIP_OUT)
        else $error("trip on new start");
    a_trip_drop:
        assert property (!GENERAL_START_OUT [*2] |-> !GENERAL_TRIP_OUT)
        else $error("trip outlives start");
    a_trip_delay: assert property ($rose(GENERAL_TRIP_OUT) |->
        st_cnt >= int'(DELAY_MIN) * CYC_MS - 2) else $error("trip early");
endmodule
bind dpp_directional_overpower_fn dpp_chk #(.CYC_MS(CYC_MS)) i_chk (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .HREADYOUT(HREADYOUT),
    .BLOCK_INPUT_STATUS(BLOCK_INPUT_STATUS),
    .VT_BLOCK_INPUT_STATUS(VT_BLOCK_INPUT_STATUS),
    .GENERAL_START_OUT(GENERAL_START_OUT),
    .GENERAL_TRIP_OUT(GENERAL_TRIP_OUT));

// >>> testbench/dpp_phasor_src.sv
// phasor front end model feeding the over-power block
`timescale 1ns/1ns
module dpp_phasor_src
(
    input wire logic clk, rst,
    input wire logic signed [15:0] amp, // current real part
    output logic meas_valid,
    output logic signed [2:0][15:0] u_re, i_re
);
    logic [4:0] cnt; // one set each 32 cycles, above the 17 minimum
    always_ff @(posedge clk or posedge rst)
        if (rst) cnt <= 5'h0;
        else cnt <= cnt + 5'h1;
    assign meas_valid = (cnt == 5'h1);
    assign u_re = {3{16'sh1000}}; // steady voltage, all phases
    assign i_re = {3{amp}}; // in phase: pure active power
endmodule

// >>> testbench/tb_top.sv
// self-checking bench of the over-power block
`timescale 1ns/1ns
module tb_top;
    import dpp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic blk = 1'b0, vt = 1'b0, rdy, st, tr, irq, mv, resp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic signed [15:0] amp = 16'sh0;
    logic signed [2:0][15:0] u_re, i_re;
    int n_errors = 0, num_checks = 0;
    always #5 clk = ~clk;
    dpp_phasor_src i_src (.clk(clk), .rst(rst), .amp(amp),
        .meas_valid(mv), .u_re(u_re), .i_re(i_re));
    dpp_directional_overpower_fn #(.CYC_MS(10)) i_dut (.CLOCK(clk),
        .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy),
        .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(resp), .MEAS_VALID(mv),
        .U_RE(u_re), .U_IM('0), .I_RE(i_re), .I_IM('0),
        .BLOCK_INPUT_STATUS(blk), .VT_BLOCK_INPUT_STATUS(vt),
        .GENERAL_START_OUT(st), .GENERAL_TRIP_OUT(tr), .IRQ(irq));
    task print_verdict;
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) $display("unexpected %0t got %h want %h", $time, g, e);
        if (g !== e) n_errors++;
    endtask
    // one bus transfer; on a read d is the expected word
    task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
        do @(posedge clk); while (rdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= w ? d : 32'h0;
        do @(posedge clk); while (rdy !== 1'b1);
        if (!w) cmp(hrdata, d);
        cmp({31'h0, resp}, 32'h0);
    endtask
    // set current and blocks, wait, check irq, trip, start
    task step(input logic signed [15:0] a, input logic b, input logic v,
              input int n, input logic [31:0] e);
        amp <= a; blk <= b; vt <= v;
        repeat (n) @(posedge clk);
        cmp({29'h0, irq, tr, st}, e);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rw(1'b0, OFS_CTRL, 32'h0);
        rw(1'b0, OFS_START_PWR, 32'h64);
        rw(1'b0, 8'h40, 32'h0);
        rw(1'b1, OFS_DELAY, 32'h5);
        rw(1'b0, OFS_DELAY, 32'hc8);
        step(16'sd400, 1'b0, 1'b0, 100, 32'h0);
        rw(1'b1, OFS_IRQ_MASK, 32'hf);
        rw(1'b1, OFS_CTRL, 32'h1);
        step(16'sd400, 1'b0, 1'b0, 100, 32'h5);
        rw(1'b0, OFS_P, 32'h0012c000);
        step(16'sd400, 1'b0, 1'b0, 1850, 32'h5);
        step(16'sd400, 1'b0, 1'b0, 150, 32'h7);
        rw(1'b0, OFS_IRQ_STAT, 32'h5);
        step(16'sd400, 1'b0, 1'b0, 3, 32'h3);
        step(16'sd400, 1'b1, 1'b0, 8, 32'h4);
        rw(1'b0, OFS_IRQ_STAT, 32'ha);
        step(16'sd400, 1'b0, 1'b0, 100, 32'h5);
        step(16'sd400, 1'b0, 1'b1, 8, 32'h4);
        rw(1'b0, OFS_IRQ_STAT, 32'h3);
        rw(1'b1, OFS_CTRL, 32'h3);
        step(16'sd400, 1'b0, 1'b0, 2500, 32'h5);
        step(16'sd130, 1'b0, 1'b0, 100, 32'h5);
        step(16'sd0, 1'b0, 1'b0, 100, 32'h4);
        step(16'sd130, 1'b0, 1'b0, 100, 32'h4);
        rw(1'b1, OFS_DIR_ANGLE, 32'hc8);
        rw(1'b0, OFS_DIR_ANGLE, 32'hb4);
        step(16'sd400, 1'b0, 1'b0, 100, 32'h4);
        rw(1'b1, OFS_CTRL, 32'h0);
        step(16'sd400, 1'b0, 1'b0, 100, 32'h4);
        print_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict;
    end
endmodule
